/* inc/qmasd_defs.vh */
// constants for the quad multiply, add/subtract and sum element
//
// Overview of operation
// - multiply pairs 0,1; add or subtract products
// - multiply pairs 2,3; add or subtract products
// - final stage adds both partial results
// - input, pipeline, output stages each bypassable
// - global clock enable and reset; enable low holds
// - each stage picks one of four clocks
`ifndef QMASD_DEFS_VH
`define QMASD_DEFS_VH

// bus geometry
`define QMASD_ADDR_W        4
`define QMASD_DATA_W        32

// register byte offsets
`define QMASD_OFS_CTRL      4'h0
`define QMASD_OFS_RES_LO    4'h4
`define QMASD_OFS_RES_HI    4'h8

// stage configuration register fields
`define QMASD_CTRL_W        10
`define QMASD_CTRL_RST      10'h000
`define QMASD_CTRL_IN_EN    0
`define QMASD_CTRL_PIPE_EN  1
`define QMASD_CTRL_OUT_EN   2
`define QMASD_CTRL_IN_SEL   5:4
`define QMASD_CTRL_PIPE_SEL 7:6
`define QMASD_CTRL_OUT_SEL  9:8

// axi response codes
`define QMASD_RESP_OKAY     2'h0
`define QMASD_RESP_SLVERR   2'h2

// number of selectable clock sources
`define QMASD_NUM_CLK       4

`endif

/* src/qmasd_stage.v */
// one register stage with clock-source select and bypass
`timescale 1ns/10ps
`default_nettype none
`include "qmasd_defs.vh"

module qmasd_stage #(
  parameter WIDTH = 8
) (
  input  wire                       sys_clk,
  input  wire                       rst_n,
  input  wire                       sync_rst,
  input  wire                       ce,
  input  wire [`QMASD_NUM_CLK-1:0]  clk_src_tick,
  input  wire [1:0]                 clk_sel,
  input  wire                       stage_en,
  input  wire [WIDTH-1:0]           d,
  output wire [WIDTH-1:0]           q
);

  reg  [WIDTH-1:0] data_r;   // stage contents
  wire             tick;     // edge of the chosen clock source

  // chosen source: one of four ticks, per stage
  assign tick = clk_src_tick[clk_sel];

  // capture on the chosen tick; reset wins over the enable
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= {WIDTH{1'b0}};
    end else if (tick && sync_rst) begin
      data_r <= {WIDTH{1'b0}};
    end else if (tick && ce) begin
      data_r <= d;
    end
  end

  // bypassed stage passes data straight through, no latency
  assign q = stage_en ? data_r : d;

endmodule
`default_nettype wire

/* src/qmasd_top.v */
// quad multiply, add/subtract and sum element with axi4-lite config
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "qmasd_defs.vh"

module qmasd_top #(
  parameter W = 18
) (
  input  wire                       sys_clk,
  input  wire                       rst_n,
  // axi4-lite slave
  input  wire [`QMASD_ADDR_W-1:0]   s_axi_awaddr,
  input  wire [2:0]                 s_axi_awprot,
  input  wire                       s_axi_awvalid,
  output wire                       s_axi_awready,
  input  wire [`QMASD_DATA_W-1:0]   s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  input  wire                       s_axi_wvalid,
  output wire                       s_axi_wready,
  output wire [1:0]                 s_axi_bresp,
  output wire                       s_axi_bvalid,
  input  wire                       s_axi_bready,
  input  wire [`QMASD_ADDR_W-1:0]   s_axi_araddr,
  input  wire [2:0]                 s_axi_arprot,
  input  wire                       s_axi_arvalid,
  output wire                       s_axi_arready,
  output wire [`QMASD_DATA_W-1:0]   s_axi_rdata,
  output wire [1:0]                 s_axi_rresp,
  output wire                       s_axi_rvalid,
  input  wire                       s_axi_rready,
  // global routing controls
  input  wire                       clock_source_0,
  input  wire                       clock_source_1,
  input  wire                       clock_source_2,
  input  wire                       clock_source_3,
  input  wire                       dsp_ce,
  input  wire                       dsp_rst,
  // operands and add/sub controls
  input  wire [W-1:0]               op_a0,
  input  wire [W-1:0]               op_b0,
  input  wire [W-1:0]               op_a1,
  input  wire [W-1:0]               op_b1,
  input  wire [W-1:0]               op_a2,
  input  wire [W-1:0]               op_b2,
  input  wire [W-1:0]               op_a3,
  input  wire [W-1:0]               op_b3,
  input  wire                       addsub0_sub,
  input  wire                       addsub1_sub,
  output wire [2*W+1:0]             dsp_result
);

  localparam PW  = 2 * W;       // product width, never truncated
  localparam RW  = 2 * W + 2;   // final sum width
  localparam BW  = 8 * W + 2;   // packed stage bus width

  // ---------------------------------------------------------------
  // configuration and bus state
  reg  [`QMASD_CTRL_W-1:0]  ctrl_r;      // stage enables and selects
  reg                       aw_got_r;    // write address held
  reg                       w_got_r;     // write data held
  reg  [`QMASD_ADDR_W-1:0]  awaddr_r;    // held write address
  reg  [`QMASD_DATA_W-1:0]  wdata_r;     // held write data
  reg  [3:0]                wstrb_r;     // held byte enables
  reg                       bvalid_r;    // write response pending
  reg  [1:0]                bresp_r;     // write response code
  reg                       rvalid_r;    // read data pending
  reg  [1:0]                rresp_r;     // read response code
  reg  [`QMASD_DATA_W-1:0]  rdata_r;     // read data
  reg  [`QMASD_CTRL_W-1:0]  ctrl_nxt;    // ctrl after byte merge

  wire [`QMASD_NUM_CLK-1:0] clk_ticks;   // the four clock sources
  wire                      wr_fire;     // both halves of write held
  wire [63:0]               res_ext;     // sign-extended result

  assign clk_ticks = {clock_source_3, clock_source_2,
                      clock_source_1, clock_source_0};

  // ---------------------------------------------------------------
  // add or subtract two products into one extra bit of headroom
  function [PW:0] fn_addsub;
    input [PW-1:0] x;
    input [PW-1:0] y;
    input          sub;
    begin
      if (sub) begin
        fn_addsub = {x[PW-1], x} - {y[PW-1], y};
      end else begin
        fn_addsub = {x[PW-1], x} + {y[PW-1], y};
      end
    end
  endfunction

  // signed full-width product of two operands
  function [PW-1:0] fn_mul;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      fn_mul = $signed(a) * $signed(b);
    end
  endfunction

  // ---------------------------------------------------------------
  // input stage: operands plus both add/sub controls
  wire [BW-1:0] in_d;   // raw operand bus
  wire [BW-1:0] in_q;   // after input stage

  assign in_d = {addsub1_sub, addsub0_sub, op_b3, op_a3, op_b2, op_a2,
                 op_b1, op_a1, op_b0, op_a0};

  qmasd_stage #(
    .WIDTH (BW)
  ) u_in_stage (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sync_rst     (dsp_rst),
    .ce           (dsp_ce),
    .clk_src_tick (clk_ticks),
    .clk_sel      (ctrl_r[`QMASD_CTRL_IN_SEL]),
    .stage_en     (ctrl_r[`QMASD_CTRL_IN_EN]),
    .d            (in_d),
    .q            (in_q)
  );

  // ---------------------------------------------------------------
  // four multipliers, products kept at double width
  wire [PW-1:0] prod0;  // a0 * b0
  wire [PW-1:0] prod1;  // a1 * b1
  wire [PW-1:0] prod2;  // a2 * b2
  wire [PW-1:0] prod3;  // a3 * b3

  assign prod0 = fn_mul(in_q[1*W-1:0*W], in_q[2*W-1:1*W]);
  assign prod1 = fn_mul(in_q[3*W-1:2*W], in_q[4*W-1:3*W]);
  assign prod2 = fn_mul(in_q[5*W-1:4*W], in_q[6*W-1:5*W]);
  assign prod3 = fn_mul(in_q[7*W-1:6*W], in_q[8*W-1:7*W]);

  // ---------------------------------------------------------------
  // pipeline stage between multipliers and adders
  wire [BW-1:0] pipe_d;  // products plus controls
  wire [BW-1:0] pipe_q;  // after pipeline stage

  assign pipe_d = {in_q[BW-1:BW-2], prod3, prod2, prod1, prod0};

  qmasd_stage #(
    .WIDTH (BW)
  ) u_pipe_stage (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sync_rst     (dsp_rst),
    .ce           (dsp_ce),
    .clk_src_tick (clk_ticks),
    .clk_sel      (ctrl_r[`QMASD_CTRL_PIPE_SEL]),
    .stage_en     (ctrl_r[`QMASD_CTRL_PIPE_EN]),
    .d            (pipe_d),
    .q            (pipe_q)
  );

  // ---------------------------------------------------------------
  // two add/sub stages, each with its own control, then the sum
  wire [PW:0]   part0;    // first partial result
  wire [PW:0]   part1;    // second partial result
  wire [RW-1:0] sum_d;    // final summation

  assign part0 = fn_addsub(pipe_q[1*PW-1:0*PW], pipe_q[2*PW-1:1*PW],
                           pipe_q[BW-2]);
  assign part1 = fn_addsub(pipe_q[3*PW-1:2*PW], pipe_q[4*PW-1:3*PW],
                           pipe_q[BW-1]);
  assign sum_d = {part0[PW], part0} + {part1[PW], part1};

  // output stage
  qmasd_stage #(
    .WIDTH (RW)
  ) u_out_stage (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sync_rst     (dsp_rst),
    .ce           (dsp_ce),
    .clk_src_tick (clk_ticks),
    .clk_sel      (ctrl_r[`QMASD_CTRL_OUT_SEL]),
    .stage_en     (ctrl_r[`QMASD_CTRL_OUT_EN]),
    .d            (sum_d),
    .q            (dsp_result)
  );

  // readback assumes W of 31 or less so the sum fits in 64 bits
  assign res_ext = {{(64-RW){dsp_result[RW-1]}}, dsp_result};

  // ---------------------------------------------------------------
  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_fire       = aw_got_r && w_got_r && !bvalid_r;

  // byte-lane merge of the configuration word
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wstrb_r[0]) begin
      ctrl_nxt[7:0] = wdata_r[7:0];
    end
    if (wstrb_r[1]) begin
      ctrl_nxt[9:8] = wdata_r[9:8];
    end
    ctrl_nxt[3] = 1'b0;   // reserved bits stay zero
  end

  // hold each write half until both are in, then answer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= {`QMASD_ADDR_W{1'b0}};
      wdata_r  <= {`QMASD_DATA_W{1'b0}};
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= `QMASD_RESP_OKAY;
      ctrl_r   <= `QMASD_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        // only the configuration word is writable
        if (awaddr_r[`QMASD_ADDR_W-1:2] == `QMASD_OFS_CTRL >> 2) begin
          ctrl_r  <= ctrl_nxt;
          bresp_r <= `QMASD_RESP_OKAY;
        end else begin
          bresp_r <= `QMASD_RESP_SLVERR;
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read path: one read at a time, data one cycle later
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `QMASD_RESP_OKAY;
      rdata_r  <= {`QMASD_DATA_W{1'b0}};
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `QMASD_RESP_OKAY;
      case (s_axi_araddr[`QMASD_ADDR_W-1:2])
        `QMASD_OFS_CTRL >> 2: begin
          rdata_r <= {{(`QMASD_DATA_W-`QMASD_CTRL_W){1'b0}}, ctrl_r};
        end
        `QMASD_OFS_RES_LO >> 2: begin
          rdata_r <= res_ext[31:0];
        end
        `QMASD_OFS_RES_HI >> 2: begin
          rdata_r <= res_ext[63:32];
        end
        default: begin
          // unmapped word reads zero with an error
          rdata_r <= {`QMASD_DATA_W{1'b0}};
          rresp_r <= `QMASD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* bench/qmasd_chk.sv */
// checker: result against operands, stage setup and clock selects
`timescale 1ns/10ps
`default_nettype none
module qmasd_chk #(
  parameter W = 18
) (
  input wire logic           sys_clk,
  input wire logic           rst_n,
  input wire logic [3:0]     s_axi_awaddr,
  input wire logic           s_axi_awvalid,
  input wire logic           s_axi_awready,
  input wire logic [31:0]    s_axi_wdata,
  input wire logic           s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  input wire logic           clock_source_0,
  input wire logic           clock_source_1,
  input wire logic           clock_source_2,
  input wire logic           clock_source_3,
  input wire logic           dsp_ce,
  input wire logic           dsp_rst,
  input wire logic [W-1:0]   op_a0,
  input wire logic [W-1:0]   op_b0,
  input wire logic [W-1:0]   op_a1,
  input wire logic [W-1:0]   op_b1,
  input wire logic [W-1:0]   op_a2,
  input wire logic [W-1:0]   op_b2,
  input wire logic [W-1:0]   op_a3,
  input wire logic [W-1:0]   op_b3,
  input wire logic           addsub0_sub,
  input wire logic           addsub1_sub,
  input wire logic [2*W+1:0] dsp_result
);
  logic [9:0] ctrl_r; // mirror of the stage setup word
  logic [9:0] dat_r;  // write data awaiting its response
  logic [3:0] adr_r;  // write address awaiting its response
  logic       aw_r;   // address half taken
  logic       w_r;    // data half taken
  // mirror applied at the response, so checks pause mid-write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 10'h000;
      dat_r  <= 10'h000;
      adr_r  <= 4'h0;
      aw_r   <= 1'b0;
      w_r    <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r  <= 1'b1;
        adr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r   <= 1'b1;
        dat_r <= s_axi_wdata[9:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_r <= 1'b0;
        w_r  <= 1'b0;
        if (adr_r[3:2] == 2'h0) ctrl_r <= dat_r;
      end
    end
  end
  wire quiet = !aw_r && !w_r && !s_axi_bvalid;
  wire byp   = quiet && (ctrl_r[2:0] == 3'h0);
  wire oon   = quiet && (ctrl_r[2:0] == 3'h4);
  wire [3:0] src = {clock_source_3, clock_source_2,
                    clock_source_1, clock_source_0};
  wire otick = src[ctrl_r[9:8]];
  // full width products, sign kept
  wire signed [2*W-1:0] p0 = $signed(op_a0) * $signed(op_b0);
  wire signed [2*W-1:0] p1 = $signed(op_a1) * $signed(op_b1);
  wire signed [2*W-1:0] p2 = $signed(op_a2) * $signed(op_b2);
  wire signed [2*W-1:0] p3 = $signed(op_a3) * $signed(op_b3);
  wire signed [2*W+1:0] e0 = addsub0_sub ? p0 - p1 : p0 + p1;
  wire signed [2*W+1:0] e1 = addsub1_sub ? p2 - p3 : p2 + p3;
  wire signed [2*W+1:0] fsum = e0 + e1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  pair0_sub_a: assert property (
    byp && addsub0_sub |-> dsp_result == fsum) else $error("pair0 sum");
  pair1_sub_a: assert property (
    byp && addsub1_sub |-> dsp_result == fsum) else $error("pair1 sum");
  final_sum_a: assert property (
    byp && !addsub0_sub && !addsub1_sub |-> dsp_result == fsum)
    else $error("final sum");
  out_lat_a: assert property (
    oon && otick && dsp_ce && !dsp_rst |=> dsp_result == $past(fsum))
    else $error("output stage load");
  ce_hold_a: assert property (
    oon && !dsp_ce && !dsp_rst |=> $stable(dsp_result))
    else $error("enable low not held");
  rst_clr_a: assert property (
    oon && otick && dsp_rst |=> dsp_result == '0)
    else $error("reset not cleared");
  tick_hold_a: assert property (
    oon && !otick |=> $stable(dsp_result)) else $error("unselected tick");
  cover property (byp && addsub0_sub && addsub1_sub);
  cover property (oon && otick && dsp_ce);
  cover property (oon && otick && dsp_rst);
endmodule
bind qmasd_top qmasd_chk #(.W(W)) u_qmasd_chk (.*);
`default_nettype wire

/* bench/qmasd_fabric.sv */
// fabric model: four clock-source ticks of differing rates
`timescale 1ns/10ps
`default_nettype none
module qmasd_fabric (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic     clock_source_0,
  output logic     clock_source_1,
  output logic     clock_source_2,
  output logic     clock_source_3
);
  logic [1:0] cnt_r; // free phase counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 2'h0;
    else cnt_r <= cnt_r + 2'h1;
  end
  // source 3 never ticks, so a stage on it must hold
  assign clock_source_0 = 1'b1;
  assign clock_source_1 = cnt_r[0];
  assign clock_source_2 = (cnt_r == 2'h3);
  assign clock_source_3 = 1'b0;
endmodule
`default_nettype wire

/* bench/qmasd_test.sv */
// testbench: bypass, latency, clock select, enable and clear
`timescale 1ns/10ps
`default_nettype none
module qmasd_test;
  localparam W = 18;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, dsp_ce, dsp_rst;
  logic addsub0_sub, addsub1_sub, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic clock_source_0, clock_source_1, clock_source_2, clock_source_3;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [W-1:0] opa [4];
  logic [W-1:0] opb [4];
  logic [2*W+1:0] dsp_result, e, eo;
  logic [63:0] e64;
  int miscompares, checks_done, cycles;
  qmasd_top #(.W(W)) u_qmasd_top (.*, .op_a0(opa[0]), .op_b0(opb[0]),
    .op_a1(opa[1]), .op_b1(opb[1]), .op_a2(opa[2]), .op_b2(opb[2]),
    .op_a3(opa[3]), .op_b3(opb[3]));
  qmasd_fabric u_qmasd_fabric (.*);
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  task test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a hang is cut short here
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      test_done();
    end
  end
  task chk(input [63:0] seen, input [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write: both halves offered together, each dropped once taken
  task axi_wr(input [3:0] a, input [31:0] dw, input [1:0] er);
    logic ad, wd, bd;
    logic [1:0] r;
    begin
      ad = 0;
      wd = 0;
      bd = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dw;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!bd) begin
        @(negedge sys_clk);
        ad = ad | (s_axi_awready & s_axi_awvalid);
        wd = wd | (s_axi_wready & s_axi_wvalid);
        bd = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge sys_clk);
        if (ad) s_axi_awvalid <= 0;
        if (wd) s_axi_wvalid <= 0;
      end
      chk(r, er);
    end
  endtask
  task axi_rd(input [3:0] a, output [31:0] dr, input [1:0] er);
    logic ad, bd;
    logic [1:0] r;
    begin
      bd = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      while (!bd) begin
        @(negedge sys_clk);
        ad = s_axi_arready & s_axi_arvalid;
        bd = s_axi_rvalid;
        dr = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge sys_clk);
        if (ad) s_axi_arvalid <= 0;
      end
      chk(r, er);
    end
  endtask
  // k of 0 gives most negative operands, widest products
  task load(input int k, input logic s0, input logic s1);
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      opa[i] <= (k == 0) ? {1'b1, {W-1{1'b0}}} : W'(k * 4099 + i * 77);
      opb[i] <= (k == 0) ? {1'b1, {W-1{1'b0}}} : W'(-k * 131 - i * 3);
    end
    addsub0_sub <= s0;
    addsub1_sub <= s1;
    @(negedge sys_clk);
  endtask
  function automatic logic [2*W+1:0] model();
    logic signed [2*W+1:0] p [4];
    for (int i = 0; i < 4; i++) p[i] = $signed(opa[i]) * $signed(opb[i]);
    return (addsub0_sub ? p[0] - p[1] : p[0] + p[1])
         + (addsub1_sub ? p[2] - p[3] : p[2] + p[3]);
  endfunction
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, dsp_rst} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot} = 0;
    {addsub0_sub, addsub1_sub, s_axi_arprot} = 0;
    {s_axi_bready, s_axi_rready, dsp_ce} = 3'h7;
    s_axi_wstrb = 4'hF;
    for (int i = 0; i < 4; i++) {opa[i], opb[i]} = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1;
    axi_rd(4'h0, d, 2'h0);
    chk(d, 0);
    axi_rd(4'hC, d, 2'h2);
    chk(d, 0);
    axi_wr(4'h4, 32'h7, 2'h2);
    for (int k = 0; k < 3; k++)
      for (int s = 0; s < 4; s++) begin
        load(k, s[0], s[1]);
        chk(dsp_result, model());
      end
    e = model();
    e64 = 64'($signed(e));
    axi_rd(4'h4, d, 2'h0);
    chk(d, e64[31:0]);
    axi_rd(4'h8, d, 2'h0);
    chk(d, e64[63:32]);
    axi_wr(4'h0, 32'h7, 2'h0);
    eo = model();
    load(5, 1, 0);
    e = model();
    for (int j = 0; j < 4; j++) begin
      chk(dsp_result, (j < 3) ? eo : e);
      @(negedge sys_clk);
    end
    for (int s = 0; s < 4; s++) begin
      axi_wr(4'h0, 32'h4 | (s << 8), 2'h0);
      eo = e;
      load(7 + s, s[1], s[0]);
      e = model();
      repeat (4) @(negedge sys_clk);
      chk(dsp_result, (s == 3) ? eo : e);
    end
    axi_wr(4'h0, 32'h4, 2'h0);
    @(posedge sys_clk);
    dsp_ce <= 0;
    eo = e;
    load(11, 1, 1);
    e = model();
    repeat (4) @(negedge sys_clk);
    chk(dsp_result, eo);
    @(posedge sys_clk);
    dsp_ce <= 1;
    repeat (2) @(negedge sys_clk);
    chk(dsp_result, e);
    @(posedge sys_clk);
    dsp_rst <= 1;
    @(posedge sys_clk);
    dsp_rst <= 0;
    @(negedge sys_clk);
    chk(dsp_result, 0);
    @(negedge sys_clk);
    chk(dsp_result, e);
    // input stage on the silent source freezes the operands
    axi_wr(4'h0, 32'h31, 2'h0);
    load(12, 0, 1);
    repeat (2) @(negedge sys_clk);
    chk(dsp_result, e);
    test_done();
  end
endmodule
`default_nettype wire
